// ### core/cts_pkg.sv
// cts_pkg: register map, fields, reset values and timing of the
// CT supervision pick-up block.
// assumes: 10 MHz hclk, AHB-Lite, 32-bit data.
package cts_pkg;

    // ********
    // clock and time base
    // ********
    localparam int CTS_CLK_HZ = 10_000_000;
    localparam int CTS_TICK_US = 5000;
    localparam int CTS_TICK_CYC = CTS_CLK_HZ / 1_000_000 * CTS_TICK_US;
    localparam int CTS_DELAY_STEP_MS = 5;

    // ********
    // register byte offsets
    // ********
    localparam logic [7:0] CTS_OFS_CTRL = 8'h00;
    localparam logic [7:0] CTS_OFS_HIGH = 8'h04;
    localparam logic [7:0] CTS_OFS_LOW = 8'h08;
    localparam logic [7:0] CTS_OFS_RATIO = 8'h0C;
    localparam logic [7:0] CTS_OFS_UNBAL = 8'h10;
    localparam logic [7:0] CTS_OFS_SUMDIF = 8'h14;
    localparam logic [7:0] CTS_OFS_DELAY = 8'h18;
    localparam logic [7:0] CTS_OFS_STATUS = 8'h1C;
    localparam logic [7:0] CTS_OFS_DIFF = 8'h20;
    localparam logic [7:0] CTS_OFS_GRPSEL = 8'h24;

    // ********
    // control field positions
    // ********
    localparam int CTS_CTRL_MODE_LSB = 0;
    localparam int CTS_CTRL_RSEL_LSB = 4;
    localparam int CTS_CTRL_RSUB_BIT = 6;

    // ********
    // setting reset values (0.01 In / 0.01 % / 5 ms units)
    // ********
    localparam logic [15:0] CTS_HIGH_RST = 16'h0078;
    localparam logic [15:0] CTS_LOW_RST = 16'h000A;
    localparam logic [15:0] CTS_RATIO_RST = 16'h03E8;
    localparam logic [15:0] CTS_UNBAL_RST = 16'h1324;
    localparam logic [15:0] CTS_SUMDIF_RST = 16'h000A;
    localparam logic [18:0] CTS_DELAY_RST = 19'h00064;
    localparam logic [15:0] CTS_PCT_FULL = 16'h2710;
    localparam logic [7:0] CTS_HYS_ON = 8'h67;
    localparam logic [7:0] CTS_HYS_OFF = 8'h61;
    localparam logic [7:0] CTS_HYS_DEN = 8'h64;

    typedef enum logic [2:0] {
        CTS_ON = 3'b000,
        CTS_BLOCKED = 3'b001,
        CTS_TEST = 3'b010,
        CTS_TEST_BLOCKED = 3'b011,
        CTS_OFF = 3'b100
    } cts_mode_t;

    typedef enum logic [1:0] {
        CTS_RES_NONE = 2'b00,
        CTS_RES_ONE = 2'b01,
        CTS_RES_TWO = 2'b10
    } cts_rsel_t;

    typedef enum logic [1:0] {
        CTS_ST_IDLE = 2'b00,
        CTS_ST_START = 2'b01,
        CTS_ST_ALARM = 2'b10,
        CTS_ST_BLOCK = 2'b11
    } cts_state_t;

endpackage

// ### core/cts_setting_mem.sv
// cts_setting_mem: two setting groups of threshold words, registered read.
// assumes: one writer, one reader, same clock as the supervision core.
module cts_setting_mem
    import cts_pkg::*;
#(
    parameter int WIDTH = 19,
    parameter int WORDS = 12
) (
    // clock and enable
    input wire logic hclk,
    input wire logic ce,
    // write side
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic [3:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    initial begin
        if (WORDS > 16 || WIDTH < 1) begin
            $error("cts_setting_mem: WORDS must be at most 16");
        end
    end

    logic [WIDTH-1:0] mem [WORDS];

    // no reset: contents are loaded by software or the core's preset walk
    always_ff @(posedge hclk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ### core/cts_supervision.sv
// cts_supervision: pick-up, alarm timing and blocking of CT supervision,
// with an AHB-Lite register slave.
// assumes: synchronous magnitudes in 0.01 In units, refreshed by mag_valid;
// blocking comes from the blocking matrix.
//
// Summary of operation
// (R1) phase and residual magnitudes compared each cycle
// (R2) release at 97, pick at 103 percent of setting
// (R3) a phase above upper limit is a fault, no alarm
// (R4) one phase must exceed the lower limit
// (R5) min over max phase ratio below setting
// (R6) negative over positive ratio above setting
// (R7) optional residual difference above its limit
// (R8) alarm after definite delay in 5 ms steps
// (R9) blocking sampled at each program cycle start
// (R10) unblocked pick-up: start and timer run
// (R11) blocked pick-up: blocked output only
// (R12) blocking during start acts as a release
// (R13) source blocks at least 5 ms before expiry
// (R14) report residual magnitude and angle difference
// (R15) report state: on, blocked, test, test blocked, off
// (R16) group switch while running, supervision continues
// (R17) timer runs only while all conditions hold
// (R18) residual none, one or two, added or subtracted; rsub is stored but not used, the gap is always the magnitude difference
// (R19) magnitudes update on 5 ms base
// (R20) a dropped condition resets timer, no alarm
module cts_supervision
    import cts_pkg::*;
#(
    parameter int MAG_W = 16,
    parameter int TICK_CYC = CTS_TICK_CYC
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // measurements
    input wire logic mag_valid,
    input wire logic [MAG_W-1:0] phase_one_fundamental,
    input wire logic [MAG_W-1:0] phase_two_fundamental,
    input wire logic [MAG_W-1:0] phase_three_fundamental,
    input wire logic [MAG_W-1:0] residual_channel_one,
    input wire logic [MAG_W-1:0] residual_channel_two,
    input wire logic [MAG_W-1:0] negative_sequence,
    input wire logic [MAG_W-1:0] positive_sequence,
    input wire logic [MAG_W-1:0] summed_residual,
    input wire logic [MAG_W-1:0] residual_angle_diff,
    // blocking matrix
    input wire logic block_in,
    // function outputs
    output logic start_out,
    output logic blocked_out,
    output logic alarm_out,
    output logic [2:0] function_operating_state
);
    initial begin
        if (MAG_W != 16 || TICK_CYC < 1) begin
            $error("cts_supervision: MAG_W must be 16 and TICK_CYC positive");
        end
    end

    // ********
    // helpers
    // ********
    // picked: release at 97 %; else pick above 103 %
    function automatic logic cts_hys_gt(input logic [15:0] m, input logic [15:0] s,
                                        input logic picked);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(m) * 24'(CTS_HYS_DEN);
        rhs = 24'(s) * 24'(picked ? CTS_HYS_OFF : CTS_HYS_ON);
        return lhs > rhs;
    endfunction

    // a/b below pct (0.01 % units): a * 10000 < pct * b
    function automatic logic cts_ratio_lt(input logic [15:0] a, input logic [15:0] b,
                                          input logic [15:0] pct);
        return (32'(a) * 32'(CTS_PCT_FULL)) < (32'(pct) * 32'(b));
    endfunction

    function automatic logic [15:0] cts_absdiff(input logic [15:0] a, input logic [15:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    // ********
    // state
    // ********
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] rsel;
        logic rsub;
        logic grp;
        logic grp_wr;
        logic [3:0] pre_idx;
        logic pre_busy;
        logic [15:0] high;
        logic [15:0] low;
        logic [15:0] ratio;
        logic [15:0] unbal;
        logic [15:0] sumdif;
        logic [18:0] delay;
        logic [15:0] p1;
        logic [15:0] p2;
        logic [15:0] p3;
        logic [15:0] res;
        logic [15:0] i2;
        logic [15:0] i1;
        logic [15:0] ang;
        logic [15:0] diff;
        logic [3:0] pk_hi;
        logic [3:0] pk_lo;
        logic pk_dif;
        logic [15:0] tick;
        logic blk;
        logic [18:0] timer;
        cts_state_t st;
        logic ap_wr;
        logic ap_rd;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
        logic ready;
    } cts_state_s_t;

    cts_state_s_t s_reg;
    cts_state_s_t s_next;
    logic [18:0] mem_rdata;
    logic mem_wr;
    logic [3:0] mem_waddr;
    logic [18:0] mem_wdata;
    logic [3:0] mem_raddr;

    cts_setting_mem #(.WIDTH(19), .WORDS(12)) u_mem (
        .hclk(hclk),
        .ce(ce),
        .wr_en(mem_wr),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    // ********
    // combinational next state
    // ********
    always_comb begin
        logic [15:0] pmax;
        logic [15:0] pmin;
        logic [15:0] rsum;
        logic cond_hi;
        logic cond_lo_any;
        logic cond_lo_below;
        logic cond_rat;
        logic cond_unb;
        logic cond_res;
        logic pickup;
        logic running;
        logic [31:0] rd;
        logic [3:0] widx;
        s_next = s_reg;
        mem_wr = 1'b0;
        mem_waddr = 4'h0;
        mem_wdata = 19'h00000;
        mem_raddr = 4'h0;
        rd = 32'h0000_0000;
        widx = 4'h0;

        // latch on the 5 ms update
        if (mag_valid) begin // R19
            s_next.p1 = phase_one_fundamental;
            s_next.p2 = phase_two_fundamental;
            s_next.p3 = phase_three_fundamental;
            s_next.i2 = negative_sequence;
            s_next.i1 = positive_sequence;
            s_next.ang = residual_angle_diff; // R14
            unique case (s_reg.rsel) // R18
                CTS_RES_ONE: s_next.res = residual_channel_one;
                CTS_RES_TWO: s_next.res = residual_channel_two;
                default: s_next.res = 16'h0000;
            endcase
        end

        // magnitudes only: polarity flips the phasor, not the size of the gap
        // healthy wiring gives equal magnitudes, so the gap is near zero
        rsum = cts_absdiff(summed_residual, s_reg.res);
        s_next.diff = rsum; // R7 R14

        // per-channel hysteresis pick-up every cycle
        s_next.pk_hi[0] = cts_hys_gt(s_reg.p1, s_reg.high, s_reg.pk_hi[0]); // R1 R2
        s_next.pk_hi[1] = cts_hys_gt(s_reg.p2, s_reg.high, s_reg.pk_hi[1]); // R1 R2
        s_next.pk_hi[2] = cts_hys_gt(s_reg.p3, s_reg.high, s_reg.pk_hi[2]); // R1 R2
        s_next.pk_hi[3] = cts_hys_gt(s_reg.res, s_reg.high, s_reg.pk_hi[3]); // R1
        s_next.pk_lo[0] = cts_hys_gt(s_reg.p1, s_reg.low, s_reg.pk_lo[0]); // R1 R2
        s_next.pk_lo[1] = cts_hys_gt(s_reg.p2, s_reg.low, s_reg.pk_lo[1]); // R1 R2
        s_next.pk_lo[2] = cts_hys_gt(s_reg.p3, s_reg.low, s_reg.pk_lo[2]); // R1 R2
        s_next.pk_lo[3] = cts_hys_gt(s_reg.res, s_reg.low, s_reg.pk_lo[3]); // R1
        s_next.pk_dif = cts_hys_gt(s_reg.diff, s_reg.sumdif, s_reg.pk_dif); // R7 R2

        pmax = s_reg.p1;
        pmin = s_reg.p1;
        if (s_reg.p2 > pmax) pmax = s_reg.p2;
        if (s_reg.p3 > pmax) pmax = s_reg.p3;
        if (s_reg.p2 < pmin) pmin = s_reg.p2;
        if (s_reg.p3 < pmin) pmin = s_reg.p3;

        cond_hi = ~|s_reg.pk_hi[2:0]; // R3
        cond_lo_any = |s_reg.pk_lo[2:0]; // R4
        cond_lo_below = ~&s_reg.pk_lo[2:0]; // R17
        cond_rat = cts_ratio_lt(pmin, pmax, s_reg.ratio); // R5
        cond_unb = !cts_ratio_lt(s_reg.i2, s_reg.i1, s_reg.unbal)
                   && (s_reg.i1 != 16'h0000); // R6
        cond_res = (s_reg.rsel == CTS_RES_NONE) || s_reg.pk_dif; // R7
        pickup = cond_hi && cond_lo_any && cond_lo_below && cond_rat && cond_unb
                 && cond_res; // R17
        running = (s_reg.mode != CTS_OFF);

        // program cycle: blocking sampled at its start
        if (s_reg.tick == 16'(TICK_CYC - 1)) begin
            s_next.tick = 16'h0000;
            s_next.blk = block_in || s_reg.mode == CTS_BLOCKED
                         || s_reg.mode == CTS_TEST_BLOCKED; // R9
        end else begin
            s_next.tick = s_reg.tick + 16'h0001;
        end

        if (!running || !pickup) begin
            s_next.st = CTS_ST_IDLE; // R20
            s_next.timer = 19'h00000; // R20
        end else begin
            unique case (s_reg.st)
                CTS_ST_IDLE: begin
                    s_next.st = s_reg.blk ? CTS_ST_BLOCK : CTS_ST_START; // R10 R11
                    s_next.timer = 19'h00000;
                end
                CTS_ST_START: begin
                    if (s_reg.blk) begin
                        s_next.st = CTS_ST_BLOCK; // R12
                        s_next.timer = 19'h00000; // R12
                    end else if (s_reg.tick == 16'(TICK_CYC - 1)) begin
                        if (s_reg.timer + 19'h00001 >= s_reg.delay) begin
                            s_next.st = CTS_ST_ALARM; // R8
                        end else begin
                            s_next.timer = s_reg.timer + 19'h00001; // R8
                        end
                    end else if (s_reg.delay == 19'h00000) begin
                        s_next.st = CTS_ST_ALARM; // R8
                    end
                end
                CTS_ST_ALARM: begin
                    if (s_reg.blk) s_next.st = CTS_ST_BLOCK; // R12
                end
                CTS_ST_BLOCK: begin
                    if (!s_reg.blk) s_next.st = CTS_ST_START;
                end
            endcase
        end

        // after reset, copy defaults into both groups
        if (s_reg.pre_busy) begin
            mem_wr = 1'b1;
            mem_waddr = s_reg.pre_idx;
            unique case (s_reg.pre_idx % 4'h6)
                4'h0: mem_wdata = {3'b000, CTS_HIGH_RST};
                4'h1: mem_wdata = {3'b000, CTS_LOW_RST};
                4'h2: mem_wdata = {3'b000, CTS_RATIO_RST};
                4'h3: mem_wdata = {3'b000, CTS_UNBAL_RST};
                4'h4: mem_wdata = {3'b000, CTS_SUMDIF_RST};
                default: mem_wdata = CTS_DELAY_RST;
            endcase
            s_next.pre_idx = s_reg.pre_idx + 4'h1;
            if (s_reg.pre_idx == 4'hB) s_next.pre_busy = 1'b0;
        end

        // ahb data phase
        s_next.ready = 1'b1;
        s_next.rdata = 32'h0000_0000;
        if (s_reg.ap_wr) begin
            unique case (s_reg.ap_addr)
                CTS_OFS_CTRL: begin
                    s_next.mode = hwdata[CTS_CTRL_MODE_LSB +: 3];
                    s_next.rsel = hwdata[CTS_CTRL_RSEL_LSB +: 2];
                    s_next.rsub = hwdata[CTS_CTRL_RSUB_BIT];
                end
                CTS_OFS_GRPSEL: begin
                    s_next.grp = hwdata[0]; // R16
                    s_next.grp_wr = hwdata[1];
                end
                default: begin
                    if (s_reg.ap_addr >= CTS_OFS_HIGH && s_reg.ap_addr <= CTS_OFS_DELAY
                        && !s_reg.pre_busy) begin
                        widx = 4'(s_reg.ap_addr[7:2] - 6'h01);
                        mem_wr = 1'b1;
                        mem_waddr = (s_reg.grp_wr ? 4'h6 : 4'h0) + widx;
                        mem_wdata = hwdata[18:0];
                    end
                end
            endcase
        end
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case ({haddr[7:2], 2'b00})
                CTS_OFS_CTRL: rd = {25'h0, s_reg.rsub, s_reg.rsel, 1'b0, s_reg.mode};
                CTS_OFS_HIGH: rd = {16'h0, s_reg.high};
                CTS_OFS_LOW: rd = {16'h0, s_reg.low};
                CTS_OFS_RATIO: rd = {16'h0, s_reg.ratio};
                CTS_OFS_UNBAL: rd = {16'h0, s_reg.unbal};
                CTS_OFS_SUMDIF: rd = {16'h0, s_reg.sumdif};
                CTS_OFS_DELAY: rd = {13'h0, s_reg.delay};
                CTS_OFS_STATUS: rd = {16'h0, s_reg.timer[12:0], s_reg.st == CTS_ST_ALARM,
                                      s_reg.st == CTS_ST_BLOCK, s_reg.st == CTS_ST_START};
                CTS_OFS_DIFF: rd = {s_reg.ang, s_reg.diff}; // R14
                CTS_OFS_GRPSEL: rd = {30'h0, s_reg.grp_wr, s_reg.grp};
                default: rd = 32'h0000_0000;
            endcase
            s_next.rdata = rd;
        end
        s_next.ap_wr = hsel && hready && htrans[1] && hwrite && hsize == 3'b010;
        s_next.ap_rd = hsel && hready && htrans[1] && !hwrite;
        s_next.ap_addr = {haddr[7:2], 2'b00};

        // active group reloaded one word per cycle so switching never halts supervision
        mem_raddr = (s_reg.grp ? 4'h6 : 4'h0) + 4'(s_reg.tick % 16'h0006); // R16
        unique case (4'(s_reg.tick % 16'h0006) - 4'h1)
            4'h0: s_next.high = mem_rdata[15:0];
            4'h1: s_next.low = mem_rdata[15:0];
            4'h2: s_next.ratio = mem_rdata[15:0];
            4'h3: s_next.unbal = mem_rdata[15:0];
            4'h4: s_next.sumdif = mem_rdata[15:0];
            default: if (!s_reg.pre_busy && s_reg.tick != 16'h0000) s_next.delay = mem_rdata;
        endcase
    end

    // ********
    // registers
    // ********
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.mode <= CTS_ON;
            s_reg.pre_busy <= 1'b1;
            s_reg.high <= CTS_HIGH_RST;
            s_reg.low <= CTS_LOW_RST;
            s_reg.ratio <= CTS_RATIO_RST;
            s_reg.unbal <= CTS_UNBAL_RST;
            s_reg.sumdif <= CTS_SUMDIF_RST;
            s_reg.delay <= CTS_DELAY_RST;
            s_reg.st <= CTS_ST_IDLE;
            s_reg.ready <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        hrdata = s_reg.rdata;
        hreadyout = s_reg.ready;
        hresp = 1'b0;
        start_out = (s_reg.st == CTS_ST_START); // R10
        blocked_out = (s_reg.st == CTS_ST_BLOCK); // R11
        alarm_out = (s_reg.st == CTS_ST_ALARM) && s_reg.mode != CTS_TEST
                    && s_reg.mode != CTS_TEST_BLOCKED;
        function_operating_state = s_reg.mode; // R15
    end
endmodule

// ### verification/cts_meas_model.sv
// cts_meas_model: measurement channels and blocking matrix in front of the block.
// assumes: the bench sets the wanted values; one hclk domain.
module cts_meas_model #(
    parameter int TICK_CYC = 10
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // wanted values from the bench
    input wire logic [8:0][15:0] tgt,
    input wire logic blk_req,
    // toward the block
    output logic mag_valid,
    output logic [8:0][15:0] mag,
    output logic block_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // ********
    // time base
    // ********
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            mag_valid <= 1'b0;
            mag <= '0;
            block_in <= 1'b0;
        end else begin
            cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
            // values move only on the time base, like a filter output would
            mag_valid <= (cnt == TICK_CYC - 1);
            if (cnt == TICK_CYC - 1) mag <= tgt;
            // the bench raises blocking ticks ahead of any expiry
            block_in <= blk_req;
        end
    end
endmodule

// ### verification/cts_supervision_chk.sv
// cts_supervision_chk: port assertions of the supervision block.
// assumes: bound to cts_supervision, one hclk domain.
module cts_supervision_chk
    import cts_pkg::*;
#(
    parameter int TICK_CYC = CTS_TICK_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // blocking and function outputs
    input wire logic block_in,
    input wire logic start_out,
    input wire logic blocked_out,
    input wire logic alarm_out,
    input wire logic [2:0] function_operating_state
);
    // blocking waits for the next program cycle, plus pipeline slack
    localparam int BLK_WIN = TICK_CYC + 6;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ********
    // assertions
    // ********
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
    chk_ready_high: assert property (hreadyout)
        else $error("wait state");
    chk_out_excl: assert property (!(start_out && blocked_out))
        else $error("start and blocked");
    chk_block_no_alarm: assert property (blocked_out |-> !alarm_out)
        else $error("alarm while blocked");
    chk_alarm_cause: assert property (
        $rose(alarm_out) |-> $past(start_out) || $past(function_operating_state[1]))
        else $error("alarm without start");
    chk_alarm_not_early: assert property ($rose(start_out) |-> (!alarm_out) [*5])
        else $error("alarm too early");
    chk_test_no_alarm: assert property (
        (function_operating_state[2:1] == 2'b01) [*3] |-> !alarm_out)
        else $error("alarm in test mode");
    chk_block_clears: assert property (
        start_out && $rose(block_in) |-> ##[1:BLK_WIN] !start_out)
        else $error("start not cleared");
endmodule

bind cts_supervision cts_supervision_chk #(.TICK_CYC(TICK_CYC)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .block_in(block_in), .start_out(start_out), .blocked_out(blocked_out),
    .alarm_out(alarm_out), .function_operating_state(function_operating_state));

// ### verification/tb_cts_supervision.sv
// tb_cts_supervision: self-checking bench of the supervision block.
// assumes: measurement model in front, AHB-Lite master tasks, short tick.
module tb_cts_supervision
    import cts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 10;
    localparam int DLY = 4;
    typedef struct packed {
        logic al;
        logic [7:0] ctrl, p1, p2, n, ps, r1, r2;
    } cts_row_t;
    // alarm, ctrl, p1, p2/p3, neg, pos, res1, res2
    cts_row_t rows [15] = '{57'h0_00_64_64_00_64_00_00, 57'h1_00_00_64_3C_64_00_00,
        57'h1_00_00_7B_3C_64_00_00, 57'h0_00_00_7C_3C_64_00_00, 57'h0_00_00_75_3C_64_00_00,
        57'h1_00_00_74_3C_64_00_00, 57'h0_00_00_64_14_64_00_00, 57'h0_00_00_05_06_0A_00_00,
        57'h0_00_00_0A_06_0A_00_00, 57'h1_00_00_0B_06_0A_00_00, 57'h1_00_00_0A_06_0A_00_00,
        57'h0_00_00_09_06_0A_00_00, 57'h0_10_00_64_3C_64_32_00, 57'h1_10_00_64_3C_64_00_00,
        57'h0_20_00_64_3C_64_00_32};
    cts_mode_t mseq [5] = '{CTS_TEST_BLOCKED, CTS_TEST, CTS_ON, CTS_OFF, CTS_BLOCKED};
    logic [31:0] dflt [6] = '{32'(CTS_HIGH_RST), 32'(CTS_LOW_RST), 32'(CTS_RATIO_RST),
        32'(CTS_UNBAL_RST), 32'(CTS_SUMDIF_RST), 32'(CTS_DELAY_RST)};
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, blk_req = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h00000000;
    logic [8:0][15:0] tgt = '0;
    logic [31:0] hrdata, rd;
    logic hreadyout, mag_valid, block_in, start_out, blocked_out, alarm_out;
    logic [8:0][15:0] mag;
    logic [2:0] function_operating_state;
    int err_count = 0, tests_run = 0, cyc = 0, n;

    always #50 hclk = ~hclk;

    cts_supervision #(.TICK_CYC(TICK)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .mag_valid(mag_valid),
        .phase_one_fundamental(mag[0]), .phase_two_fundamental(mag[1]),
        .phase_three_fundamental(mag[2]), .residual_channel_one(mag[3]),
        .residual_channel_two(mag[4]), .negative_sequence(mag[5]), .positive_sequence(mag[6]),
        .summed_residual(mag[7]), .residual_angle_diff(mag[8]), .block_in(block_in),
        .start_out(start_out), .blocked_out(blocked_out), .alarm_out(alarm_out),
        .function_operating_state(function_operating_state));

    cts_meas_model #(.TICK_CYC(TICK)) u_meas (.hclk(hclk), .hresetn(hresetn), .tgt(tgt),
        .blk_req(blk_req), .mag_valid(mag_valid), .mag(mag), .block_in(block_in));

    // ********
    // tasks
    // ********
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // single transfer; waits for hready
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic apply(input cts_row_t r);
        tgt <= {16'h1234, 16'h0032, 8'h00, r.ps, 8'h00, r.n, 8'h00, r.r2, 8'h00, r.r1,
                8'h00, r.p2, 8'h00, r.p2, 8'h00, r.p1};
    endtask

    task automatic wait_ticks(input int t);
        repeat (t * TICK) @(posedge hclk);
    endtask

    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            summarize();
        end
    end

    // ********
    // sequence
    // ********
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
        ahb(CTS_OFS_DELAY, 1'b1, 32'h00000004, rd);
        foreach (rows[i]) begin
            ahb(CTS_OFS_CTRL, 1'b1, {24'h000000, rows[i].ctrl}, rd);
            apply(rows[i]);
            wait_ticks(DLY + 4);
            ahb(CTS_OFS_STATUS, 1'b0, 32'h00000000, rd);
            check(alarm_out, rows[i].al);
            check(rd[2], rows[i].al);
            check(blocked_out, 1'b0);
        end
        ahb(CTS_OFS_DIFF, 1'b0, 32'h00000000, rd);
        check(rd[31:16], 16'h1234);
        $display("condition table done");
        ahb(CTS_OFS_CTRL, 1'b1, 32'h00000000, rd);
        apply(rows[0]);
        wait_ticks(3);
        apply(rows[1]);
        while (start_out !== 1'b1) @(posedge hclk);
        wait_ticks(2);
        apply(rows[0]);
        while (start_out !== 1'b0) @(posedge hclk);
        check(alarm_out, 1'b0);
        apply(rows[1]);
        while (start_out !== 1'b1) @(posedge hclk);
        n = 0;
        while (alarm_out !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
        check(n >= (DLY - 1) * TICK && n <= (DLY + 1) * TICK, 1'b1);
        $display("alarm delay done");
        apply(rows[0]);
        wait_ticks(3);
        apply(rows[1]);
        while (start_out !== 1'b1) @(posedge hclk);
        blk_req <= 1'b1;
        wait_ticks(2);
        check(start_out, 1'b0);
        wait_ticks(DLY + 1);
        check(alarm_out, 1'b0);
        blk_req <= 1'b0;
        apply(rows[0]);
        wait_ticks(3);
        blk_req <= 1'b1;
        wait_ticks(2);
        apply(rows[1]);
        wait_ticks(3);
        check(blocked_out, 1'b1);
        check(start_out, 1'b0);
        wait_ticks(DLY + 1);
        check(alarm_out, 1'b0);
        blk_req <= 1'b0;
        wait_ticks(3);
        check(start_out, 1'b1);
        $display("blocking done");
        foreach (mseq[i]) begin
            ahb(CTS_OFS_CTRL, 1'b1, {29'h00000000, mseq[i]}, rd);
            wait_ticks(DLY + 4);
            check(function_operating_state, mseq[i]);
            check(alarm_out, mseq[i] == CTS_ON);
            check(blocked_out, mseq[i][0]);
        end
        $display("modes done");
        ahb(CTS_OFS_GRPSEL, 1'b1, 32'h00000002, rd);
        ahb(CTS_OFS_DELAY, 1'b1, 32'h00000002, rd);
        repeat (10) @(posedge hclk);
        ahb(CTS_OFS_DELAY, 1'b0, 32'h00000000, rd);
        check(rd, 32'h00000004);
        ahb(CTS_OFS_GRPSEL, 1'b1, 32'h00000003, rd);
        repeat (10) @(posedge hclk);
        ahb(CTS_OFS_DELAY, 1'b0, 32'h00000000, rd);
        check(rd, 32'h00000002);
        $display("setting groups done");
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
        foreach (dflt[i]) begin
            ahb(CTS_OFS_HIGH + 8'(4 * i), 1'b0, 32'h00000000, rd);
            check(rd, dflt[i]);
        end
        check(function_operating_state, CTS_ON);
        ahb(8'h3C, 1'b1, 32'hFFFFFFFF, rd);
        ahb(8'h3C, 1'b0, 32'h00000000, rd);
        check(rd, 32'h00000000);
        $display("reset and map done");
        summarize();
    end
endmodule
